// ### hw/eipl_pkg.sv
// Constants shared by the external interrupt pin latch design files.
// Assumes an 8-bit register port with a 2-bit word address.
package eipl_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 2;
   localparam int VEC_W = 16;

   // Register word offsets.
   localparam logic [ADDR_W-1:0] IRQ_STATUS_CONTROL_OFS = 2'h0;
   localparam logic [ADDR_W-1:0] CONFIG_REG_TWO_OFS = 2'h1;

   // Field positions of irq_status_control.
   localparam int MODE_POS = 0;
   localparam int IRQ_MASK_POS = 1;
   localparam int ACK_POS = 2;
   localparam int PENDING_POS = 3;

   // Field position of config_reg_two.
   localparam int FUNC_EN_POS = 0;

   // Reset values.
   localparam logic MODE_RST = 1'b0;
   localparam logic IRQ_MASK_RST = 1'b0;
   localparam logic FUNC_EN_RST = 1'b0;
   localparam logic PIN_IDLE_RST = 1'b1;
   localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

   // Vector address of this interrupt; the value is arbitrary.
   localparam logic [VEC_W-1:0] IRQ_VEC_ADDR = 16'h0ff0;
   localparam logic [VEC_W-1:0] VEC_NONE = 16'h0000;

endpackage

// ### hw/eipl_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time with respect to the clock.
`timescale 1ns/1ps
module eipl_sync import eipl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_async,
   output logic o_sync
);

   logic stage1;

   // The first stage feeds only the second, so a metastable value never fans out.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         stage1 <= PIN_IDLE_RST;
         o_sync <= PIN_IDLE_RST;
      end
      else
      begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end

endmodule // eipl_sync

// ### hw/eipl_fall_det.sv
// Falling edge detector on an already synchronised active-low level.
// Assumes the input is on the same clock; output is a one-cycle pulse.
`timescale 1ns/1ps
module eipl_fall_det import eipl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_level,
   output logic o_fall
);

   logic prev;

   // Reset to the idle high level so an idle pin makes no edge after reset.
   // A pin held low through reset does show one edge; the enable gate blocks it.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         prev <= PIN_IDLE_RST;
      else
         prev <= i_level;
   end

   assign o_fall = prev & ~i_level;

endmodule // eipl_fall_det

// ### hw/eipl_top.sv
// External interrupt pin latch: pin sync, edge and level detect, request latch,
// mask gating and the status/control registers.
// Assumes the CPU drives vector fetch and global mask on the same clock.
`timescale 1ns/1ps

//Contract
// - Interrupt function works only when enabled
// - Latch holds until acknowledge, disable or reset
// - Vector fetch acknowledge clears the latch
// - Writing one to acknowledge clears latch
// - Edge-only after reset; mode selects level
// - Reset clears latch and mode bit
// - Falling pin edge sets the latch
// - Module mask withholds request from CPU
// - Global CPU mask also blocks request
// - Level mode clears on acknowledge and high
// - Level mode pending while pin low
// - Acknowledge and pin high in any order
// - Edge after acknowledge sets latch again
// - Presented request supplies vector address
// - Edge mode acknowledge clears at once
// - Pending flag readable regardless of mask
// - Pin level visible for branch instructions
// - Acknowledge bit is write-only, reads zero
// - Module mask bit is read/write
module eipl_top import eipl_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   input wire logic I_IRQ_N,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic I_VEC_FETCH,
   input wire logic I_CCR_IRQ_MASK_BIT,
   output logic [DATA_W-1:0] O_RDATA,
   output logic O_IRQ_REQ,
   output logic [VEC_W-1:0] O_VEC_ADDR,
   output logic O_PIN_LEVEL,
   output logic O_PORT_PIN,
   output logic O_PULLUP_EN
);

   logic pin_sync;
   logic pin_fall;
   logic pin_low;
   logic ext_irq_function_enable;
   logic irq_mask_bit;
   logic mode;
   logic irq_latch;
   logic irq_pending_flag;
   logic wr_scr;
   logic wr_cfg;
   logic sw_ack;
   logic any_ack;
   logic edge_set;
   logic level_hold;
   logic req_pend;
   logic presented;
   logic [DATA_W-1:0] next_rdata;

   eipl_sync u_sync
   (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_async(I_IRQ_N),
      .o_sync(pin_sync)
   );

   eipl_fall_det u_fall
   (
      .i_clk(I_CLK_SYS),
      .i_nrst(I_NRST),
      .i_level(pin_sync),
      .o_fall(pin_fall)
   );

   assign pin_low = ~pin_sync;

   // Register port decode.
   assign wr_scr = I_WR && (I_ADDR == IRQ_STATUS_CONTROL_OFS);
   assign wr_cfg = I_WR && (I_ADDR == CONFIG_REG_TWO_OFS);

   assign sw_ack = wr_scr && I_WDATA[ACK_POS];
   assign any_ack = I_VEC_FETCH || sw_ack;

   assign edge_set = ext_irq_function_enable && pin_fall;
   assign level_hold = ext_irq_function_enable && mode && pin_low;

   // The level term sits beside the latch, so in level mode an acknowledge
   // while the pin is low leaves the request up until the pin returns high.
   assign req_pend = irq_latch || level_hold;
   assign presented = req_pend && !irq_mask_bit && !I_CCR_IRQ_MASK_BIT;

   // Configuration enable for the pin's interrupt function.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
         ext_irq_function_enable <= FUNC_EN_RST;
      else if (wr_cfg)
         ext_irq_function_enable <= I_WDATA[FUNC_EN_POS];
   end

   // Mode and module mask bits.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         mode <= MODE_RST;
         irq_mask_bit <= IRQ_MASK_RST;
      end
      else if (wr_scr)
      begin
         mode <= I_WDATA[MODE_POS];
         irq_mask_bit <= I_WDATA[IRQ_MASK_POS];
      end
   end

   // Request latch. A new edge in the same cycle as an acknowledge wins,
   // so an event arriving during the clear is never lost.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
         irq_latch <= 1'b0;
      else if (edge_set)
         irq_latch <= 1'b1;
      else if (!ext_irq_function_enable)
         irq_latch <= 1'b0;
      else if (any_ack)
         irq_latch <= 1'b0;
   end

   // Pending flag ignores both masks so polling software sees it.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
         irq_pending_flag <= 1'b0;
      else
         irq_pending_flag <= req_pend;
   end

   // Request toward the priority logic and the vector it selects.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         O_IRQ_REQ <= 1'b0;
         O_VEC_ADDR <= VEC_NONE;
      end
      else
      begin
         O_IRQ_REQ <= presented;
         O_VEC_ADDR <= presented ? IRQ_VEC_ADDR : VEC_NONE;
      end
   end

   // Pin level views and the shared-function path. The pullup follows the
   // enable since the pin is then an interrupt input.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         O_PIN_LEVEL <= PIN_IDLE_RST;
         O_PORT_PIN <= PIN_IDLE_RST;
         O_PULLUP_EN <= FUNC_EN_RST;
      end
      else
      begin
         O_PIN_LEVEL <= pin_sync;
         O_PORT_PIN <= ext_irq_function_enable ? PIN_IDLE_RST : pin_sync;
         O_PULLUP_EN <= ext_irq_function_enable;
      end
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_comb
   begin
      next_rdata = RDATA_RST;
      if (I_RD)
      begin
         case (I_ADDR)
            IRQ_STATUS_CONTROL_OFS:
            begin
               next_rdata[MODE_POS] = mode;
               next_rdata[IRQ_MASK_POS] = irq_mask_bit;
               next_rdata[ACK_POS] = 1'b0;
               next_rdata[PENDING_POS] = irq_pending_flag;
            end
            CONFIG_REG_TWO_OFS:
               next_rdata[FUNC_EN_POS] = ext_irq_function_enable;
            default:
               next_rdata = RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
         O_RDATA <= RDATA_RST;
      else
         O_RDATA <= next_rdata;
   end

   default clocking cb @(posedge I_CLK_SYS);
   endclocking

   default disable iff (!I_NRST);

   sequence s_clean_ack;
      any_ack && !edge_set && ext_irq_function_enable;
   endsequence

   sequence s_latch_gone;
      !irq_latch;
   endsequence

   sequence s_pin_fall;
      ext_irq_function_enable && pin_fall;
   endsequence

   sequence s_req_seen;
      O_IRQ_REQ && (O_VEC_ADDR == IRQ_VEC_ADDR);
   endsequence

   edge_sets_latch_a: assert property (s_pin_fall |=> irq_latch ##1 irq_pending_flag)
      else $error("falling edge did not set the latch");

   edge_ack_clear_a: assert property (!mode ##0 s_clean_ack |=> s_latch_gone)
      else $error("acknowledge did not clear latch in edge mode");

   latch_holds_a: assert property (irq_latch && !any_ack && ext_irq_function_enable
      |=> irq_latch)
      else $error("latch dropped without acknowledge");

   level_pending_a: assert property (mode && ext_irq_function_enable && pin_low
      |=> irq_pending_flag)
      else $error("level mode request dropped while pin low");

   both_clear_a: assert property (!irq_latch && !(mode && pin_low) && !pin_fall
      |=> !irq_pending_flag)
      else $error("request stayed pending after both clear conditions");

   ack_low_hold_a: assert property (mode && ext_irq_function_enable && pin_low
      ##0 s_clean_ack |=> s_latch_gone ##0 irq_pending_flag)
      else $error("acknowledge alone cleared level mode request");

   mask_blocks_a: assert property (irq_mask_bit |=> !O_IRQ_REQ)
      else $error("request presented while module mask set");

   global_blocks_a: assert property (I_CCR_IRQ_MASK_BIT |=> !O_IRQ_REQ)
      else $error("request presented while global mask set");

   vector_present_a: assert property (req_pend && !irq_mask_bit && !I_CCR_IRQ_MASK_BIT
      |=> s_req_seen)
      else $error("presented request lacks vector address");

   disabled_quiet_a: assert property (!ext_irq_function_enable && !wr_cfg
      |=> !irq_latch ##1 !O_IRQ_REQ)
      else $error("latch set while interrupt function disabled");

   ack_reads_zero_a: assert property (I_RD |=> !O_RDATA[ACK_POS])
      else $error("acknowledge bit read back as one");

   mode_write_a: assert property (wr_scr |=> mode == $past(I_WDATA[MODE_POS]))
      else $error("mode bit did not take written value");

   single_edge_a: assert property (pin_fall |=> !pin_fall)
      else $error("one transition produced two edges");

   flag_read_a: assert property (I_RD && I_ADDR == IRQ_STATUS_CONTROL_OFS
      |=> O_RDATA[PENDING_POS] == $past(irq_pending_flag))
      else $error("pending flag read back wrong");

   set_beats_ack_a: assert property (edge_set && any_ack |=> irq_latch)
      else $error("edge lost to a simultaneous acknowledge");

   fetch_clears_a: assert property (I_VEC_FETCH && !edge_set && ext_irq_function_enable
      |=> !irq_latch)
      else $error("vector fetch did not clear the latch");

   masked_flag_a: assert property (irq_latch && irq_mask_bit |=> irq_pending_flag)
      else $error("pending flag hidden by module mask");

   pin_level_view_a: assert property (pin_low |=> !O_PIN_LEVEL)
      else $error("pin level view missed a low pin");

   port_held_a: assert property (ext_irq_function_enable |=> O_PULLUP_EN && O_PORT_PIN)
      else $error("enabled pin still shown on port path");

   mask_write_a: assert property (wr_scr
      |=> irq_mask_bit == $past(I_WDATA[IRQ_MASK_POS]))
      else $error("mask bit did not take written value");

   vec_idle_a: assert property (!O_IRQ_REQ |-> O_VEC_ADDR == VEC_NONE)
      else $error("vector address shown without a request");

endmodule // eipl_top

// ### verif/eipl_src_model.sv
// Model of the external source that pulls the active-low request pin.
// Assumes the pin has a pull-up, so a released source leaves it high.
`timescale 1ns/1ps
module eipl_src_model
(
   input wire logic i_drive_low,
   output logic o_pin_n
);
   // The 2 ns lag keeps pin changes away from the clock edge, as a real source would be.
   assign #2 o_pin_n = ~i_drive_low;
endmodule // eipl_src_model

// ### verif/eipl_top_tb.sv
// Self-checking bench for the external interrupt pin latch.
// Assumes the register port answers one cycle after the read strobe.
`timescale 1ns/1ps
module eipl_top_tb import eipl_pkg::*;
;
   localparam logic [ADDR_W-1:0] SCR = IRQ_STATUS_CONTROL_OFS;
   localparam logic [ADDR_W-1:0] CFG = CONFIG_REG_TWO_OFS;
   localparam logic [DATA_W-1:0] MODE_V = 8'h01 << MODE_POS;
   localparam logic [DATA_W-1:0] MASK_V = 8'h01 << IRQ_MASK_POS;
   localparam logic [DATA_W-1:0] ACK_V = 8'h01 << ACK_POS;
   localparam logic [DATA_W-1:0] PEND_V = 8'h01 << PENDING_POS;
   localparam logic [DATA_W-1:0] EN_V = 8'h01 << FUNC_EN_POS;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic vf = 1'b0;
   logic gmask = 1'b0;
   logic low = 1'b0;
   logic pin_n;
   logic [ADDR_W-1:0] addr = 2'h0;
   logic [DATA_W-1:0] wdata = 8'h00;
   logic [DATA_W-1:0] rdata;
   logic req;
   logic [VEC_W-1:0] vec;
   logic pin_level;
   logic port_pin;
   logic pullup_en;
   logic [DATA_W-1:0] d;
   int n_errors = 0;
   int checks_done = 0;
   always #2.5 clk = ~clk;
   eipl_src_model src_u (.i_drive_low(low), .o_pin_n(pin_n));
   eipl_top dut_u (.I_CLK_SYS(clk), .I_NRST(nrst), .I_IRQ_N(pin_n), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_VEC_FETCH(vf), .I_CCR_IRQ_MASK_BIT(gmask),
      .O_RDATA(rdata), .O_IRQ_REQ(req), .O_VEC_ADDR(vec), .O_PIN_LEVEL(pin_level),
      .O_PORT_PIN(port_pin), .O_PULLUP_EN(pullup_en));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic pin(input logic l);
      @(posedge clk);
      low <= l;
      idle(7);
   endtask
   task automatic ack(input logic [DATA_W-1:0] ctl);
      wrr(SCR, ctl | ACK_V);
      idle(3);
   endtask
   task automatic vfetch;
      @(posedge clk);
      vf <= 1'b1;
      @(posedge clk);
      vf <= 1'b0;
      idle(3);
   endtask
   task automatic st(input logic e);
      chk({15'h0000, req}, {15'h0000, e});
      chk(vec, e ? IRQ_VEC_ADDR : VEC_NONE);
   endtask
   task automatic do_reset;
      @(posedge clk);
      nrst <= 1'b0;
      idle(16);
      @(posedge clk);
      nrst <= 1'b1;
      idle(2);
   endtask
   task automatic t_reset;
      rdr(SCR, d);
      chk(d, 8'h00);
      rdr(CFG, d);
      chk(d, 8'h00);
      chk(pin_level, 1'b1);
      chk(pullup_en, 1'b0);
      st(1'b0);
   endtask
   task automatic t_disabled;
      pin(1'b1);
      st(1'b0);
      chk(port_pin, 1'b0);
      pin(1'b0);
      chk(port_pin, 1'b1);
      wrr(2'h2, 8'hff);
      rdr(2'h2, d);
      chk(d, 8'h00);
      rdr(SCR, d);
      chk(d, 8'h00);
   endtask
   task automatic t_edge;
      wrr(CFG, EN_V);
      idle(2);
      chk(pullup_en, 1'b1);
      chk(port_pin, 1'b1);
      pin(1'b1);
      st(1'b1);
      chk(pin_level, 1'b0);
      idle(10);
      st(1'b1);
      wrr(SCR, MASK_V);
      idle(3);
      st(1'b0);
      rdr(SCR, d);
      chk(d, MASK_V | PEND_V);
      wrr(SCR, 8'h00);
      @(posedge clk);
      gmask <= 1'b1;
      idle(3);
      st(1'b0);
      @(posedge clk);
      gmask <= 1'b0;
      idle(3);
      st(1'b1);
      ack(8'h00);
      st(1'b0);
      rdr(SCR, d);
      chk(d, 8'h00);
      idle(10);
      st(1'b0);
      pin(1'b0);
      chk(pin_level, 1'b1);
      pin(1'b1);
      st(1'b1);
      vfetch;
      st(1'b0);
      pin(1'b0);
      @(posedge clk);
      low <= 1'b1;
      @(posedge clk);
      ack(8'h00);
      idle(4);
      st(1'b1);
      vfetch;
      st(1'b0);
      pin(1'b0);
   endtask
   task automatic t_level;
      wrr(SCR, MODE_V);
      pin(1'b1);
      st(1'b1);
      ack(MODE_V);
      st(1'b1);
      rdr(SCR, d);
      chk(d, MODE_V | PEND_V);
      pin(1'b0);
      st(1'b0);
      pin(1'b1);
      pin(1'b0);
      st(1'b1);
      ack(MODE_V | MASK_V);
      wrr(SCR, MODE_V);
      idle(3);
      st(1'b0);
      pin(1'b1);
      vfetch;
      st(1'b1);
      pin(1'b0);
      st(1'b0);
      pin(1'b1);
      st(1'b1);
      do_reset;
      st(1'b0);
      rdr(SCR, d);
      chk(d, 8'h00);
      wrr(CFG, EN_V);
      idle(8);
      st(1'b0);
      pin(1'b0);
   endtask
   task automatic results;
      if (n_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_errors++;
      results;
   end
   initial
   begin
      idle(16);
      @(posedge clk);
      nrst <= 1'b1;
      idle(2);
      t_reset;
      t_disabled;
      t_edge;
      t_level;
      results;
   end
endmodule // eipl_top_tb
